//--- insn_decode_pkg.sv
// package: constants, field positions and carrier types for the instruction format decoder
package insn_decode_pkg;

   // word geometry; field positions are little-endian indices of the 16-bit word
   localparam int WORD_W      = 16;
   localparam int SLOT_W      = 6;
   localparam int REG_ADDR_W  = 4;

   // primary opcode, top four bits
   localparam int OP_HI       = 15;
   localparam int OP_LO       = 12;
   localparam logic [3:0] OP_STACK = 4'h0;
   localparam logic [3:0] OP_SUB1  = 4'h1;
   localparam logic [3:0] OP_SUB2  = 4'h2;
   localparam logic [3:0] OP_SUB3  = 4'h3;
   localparam logic [3:0] OP_STORE = 4'h5;

   // sub-opcode fields
   localparam int SUB23_HI    = 11;
   localparam int SUB23_LO    = 8;
   localparam int SUB1_HI     = 10;
   localparam int SUB1_LO     = 6;
   localparam int MINI_HI     = 7;
   localparam int MINI_LO     = 4;
   localparam logic [3:0] SUB_MINI = 4'h0;

   // stack slots
   localparam int SLOT_A_HI   = 11;
   localparam int SLOT_A_LO   = 6;
   localparam int SLOT_B_HI   = 5;
   localparam int SLOT_B_LO   = 0;
   localparam logic [5:0] NO_OPERATION = 6'h00;

   // single-bit fields
   localparam int BIT_X       = 11;
   localparam int BIT_IND     = 10;
   localparam int BIT_BR_SIGN = 5;
   localparam int BIT_SRC_DB  = 4;
   localparam int BIT_SPC_EXT = 0;
   localparam int BIT_LP_SIGN = 8;

   // multi-bit argument fields
   localparam int CNT_HI      = 5;
   localparam int CNT_LO      = 0;
   localparam int BR_HI       = 4;
   localparam int BR_LO       = 0;
   localparam int MV_HI       = 7;
   localparam int MV_LO       = 5;
   localparam int SDEC_HI     = 1;
   localparam int SDEC_LO     = 0;
   localparam int IMM_HI      = 7;
   localparam int IMM_LO      = 0;
   localparam int FJ_HI       = 7;
   localparam int FJ_LO       = 4;
   localparam int FK_HI       = 3;
   localparam int FK_LO       = 0;
   localparam int REGS_HI     = 6;
   localparam int REGS_LO     = 0;
   localparam int LP_HI       = 11;
   localparam int LP_LO       = 9;
   localparam int MD_HI       = 9;
   localparam int MD_LO       = 0;

   // register port map (word indices)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_WORD   = 4'h2;
   localparam int CTRL_LOOKAHEAD = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0001;

   typedef enum logic [5:0] {
      GRP_NONE  = 6'h00,
      GRP_STACK = 6'h01,
      GRP_SUB1  = 6'h02,
      GRP_SUB2  = 6'h04,
      GRP_SUB3  = 6'h08,
      GRP_MEM   = 6'h10,
      GRP_LOOP  = 6'h20
   } group_e;

   typedef struct packed {
      logic       carry;
      logic       overflow;
      logic [1:0] cond_code;
   } indicators_s;

   typedef struct packed {
      group_e      group;
      logic [3:0]  primary;
      logic [4:0]  sub1_op;
      logic [3:0]  sub_op;
      logic        mini_valid;
      logic [3:0]  mini_op;
      logic [5:0]  slot_a;
      logic [5:0]  slot_b;
      logic        index_bit;
      logic        indirect;
      logic [15:0] count_eff;
      logic        br_minus;
      logic [4:0]  br_disp;
      logic [2:0]  move_op;
      logic        move_src_db;
      logic [1:0]  move_sdec;
      logic        special_ext;
      logic [7:0]  imm8;
      logic [3:0]  field_start;
      logic [3:0]  field_len;
      logic [6:0]  reg_sel;
      logic [3:0]  io_sdisp;
      logic        loop_minus;
      logic [7:0]  loop_disp;
      logic        post_index;
      logic [9:0]  mode_disp;
   } decode_s;

endpackage

//--- insn_decode.sv
// instruction format decoder with paired stack-op sequencing
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// RULE1: top four bits are the primary opcode: memory, loop or sub-opcode group.
// RULE2: 0000 is stack group; 0001, 0010, 0011 are sub-opcode groups one to three.
// RULE3: groups two/three sub-opcode in bits 4-7; group one in bits 5-9.
// RULE4: when called for, a mini opcode comes from bits 8-11.
// RULE5: stack word low twelve bits form two six-bit slots, any code.
// RULE6: left slot runs before right slot; interrupt may come between them.
// RULE7: indicators reflect only the last stack op actually executed.
// RULE8: right slot holding no_operation is skipped by look-ahead, costing no time.
// RULE9: shift type bits 5-9, count 10-15, index added when bit 4 set.
// RULE10: branch: bit 4 indirect, 5-9 type, 11-15 offset, bit 10 sign.
// RULE11: bit test position 10-15, index added when bit 4 set.
// RULE12: move code bits 8-10 under group two zero; bit 11 base select.
// RULE13: move bits 14-15 give stack-pointer decrement to drop parameters.
// RULE14: special group: bits 8-11 plus bit 15 encode, 12-14 ignored.
// RULE15: immediate in groups two/three: op bits 4-7, operand low byte.
// RULE16: field ops: bits 4-7 op, low byte split into start and length.
// RULE17: register control: op bits 4-7, register selection bits 9-15.
// RULE18: program control group three: low byte is call displacement or return count.
// RULE19: I/O: special opcode bits 8-11, bits 12-15 stack displacement.
// RULE20: loop control: opcode 05 with special bits 4-6, offset 8-15, sign bit 7.
// RULE21: memory ref: op 0-3, index bit 4, indirect bit 5, mode 6-15, post-index.
// RULE22: status flag records that right slot holds a valid non-no_operation code.
// RULE23: decode from latched word within one cycle; outputs cleared on reset.
module insn_decode
   import insn_decode_pkg::*;
#(
   parameter logic [2:0] LOOP_MARK = 3'h7
)(
   input  wire logic                            ref_clk,
   input  wire logic                            rstn,
   input  wire logic [insn_decode_pkg::WORD_W-1:0]      fetch_word,
   input  wire logic                            fetch_load,
   input  wire logic [insn_decode_pkg::WORD_W-1:0]      index_reg,
   input  wire logic                            op_done,
   input  wire insn_decode_pkg::indicators_s    ind_in,
   input  wire logic                            irq_pending,
   input  wire logic                            irq_resume,
   input  wire logic [insn_decode_pkg::REG_ADDR_W-1:0]  reg_addr,
   input  wire logic [insn_decode_pkg::WORD_W-1:0]      reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic [insn_decode_pkg::WORD_W-1:0]           reg_rdata,
   output insn_decode_pkg::decode_s                     dec,
   output logic                                         dec_valid,
   output logic [insn_decode_pkg::SLOT_W-1:0]           stack_op,
   output logic                                         stack_issue,
   output logic                                         stack_slot_b,
   output logic                                         irq_take,
   output insn_decode_pkg::indicators_s                 indicators,
   output logic                                         right_slot_valid,
   output logic                                         seq_busy
);
   import insn_decode_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_SLOT_A = 4'h2,
      ST_SLOT_B = 4'h4,
      ST_HELD   = 4'h8
   } seq_state_e;

   seq_state_e                  state_ff;
   seq_state_e                  nxt_state;
   decode_s                     dec_ff;
   decode_s                     nxt_dec;
   logic [WORD_W-1:0]           word_ff;
   logic                        dec_valid_ff;
   logic [SLOT_W-1:0]           stack_op_ff;
   logic                        stack_issue_ff;
   logic                        slot_b_ff;
   logic                        irq_take_ff;
   indicators_s                 ind_ff;
   logic                        right_valid_ff;
   logic                        busy_ff;
   logic [WORD_W-1:0]           ctrl_ff;
   logic [WORD_W-1:0]           rdata_ff;
   logic                        accept;
   logic                        is_stack;
   logic                        b_is_nop;
   logic                        lookahead_en;

   // a word is only taken between instructions; a load while busy is dropped
   assign accept       = fetch_load && (state_ff == ST_IDLE);
   assign is_stack     = (fetch_word[OP_HI:OP_LO] == OP_STACK);
   assign b_is_nop     = (fetch_word[SLOT_B_HI:SLOT_B_LO] == NO_OPERATION);
   assign lookahead_en = ctrl_ff[CTRL_LOOKAHEAD];

   // field extraction from the incoming word, registered on the accept cycle
   always_comb begin
      logic [3:0]  prim;
      logic [3:0]  sub23;
      logic [15:0] count_base;
      prim       = fetch_word[OP_HI:OP_LO];
      sub23      = fetch_word[SUB23_HI:SUB23_LO];
      count_base = {10'h000, fetch_word[CNT_HI:CNT_LO]};
      nxt_dec             = '0;
      // argument fields are extracted for every word; the group says which ones matter
      nxt_dec.primary     = prim; // RULE1
      nxt_dec.sub1_op     = fetch_word[SUB1_HI:SUB1_LO]; // RULE3
      nxt_dec.sub_op      = sub23; // RULE3
      nxt_dec.slot_a      = fetch_word[SLOT_A_HI:SLOT_A_LO]; // RULE5
      nxt_dec.slot_b      = fetch_word[SLOT_B_HI:SLOT_B_LO]; // RULE5
      nxt_dec.index_bit   = fetch_word[BIT_X]; // RULE21
      nxt_dec.indirect    = fetch_word[BIT_IND]; // RULE21
      nxt_dec.count_eff   = fetch_word[BIT_X] ? count_base + index_reg : count_base; // RULE9 RULE11
      nxt_dec.br_minus    = fetch_word[BIT_BR_SIGN]; // RULE10
      nxt_dec.br_disp     = fetch_word[BR_HI:BR_LO]; // RULE10
      nxt_dec.move_op     = fetch_word[MV_HI:MV_LO]; // RULE12
      nxt_dec.move_src_db = fetch_word[BIT_SRC_DB]; // RULE12
      nxt_dec.move_sdec   = fetch_word[SDEC_HI:SDEC_LO]; // RULE13
      nxt_dec.special_ext = fetch_word[BIT_SPC_EXT]; // RULE14
      nxt_dec.imm8        = fetch_word[IMM_HI:IMM_LO]; // RULE15 RULE18
      nxt_dec.field_start = fetch_word[FJ_HI:FJ_LO]; // RULE16
      nxt_dec.field_len   = fetch_word[FK_HI:FK_LO]; // RULE16
      nxt_dec.reg_sel     = fetch_word[REGS_HI:REGS_LO]; // RULE17
      nxt_dec.io_sdisp    = fetch_word[FK_HI:FK_LO]; // RULE19
      // indirection resolves first, the index is then added
      nxt_dec.post_index  = fetch_word[BIT_X] & fetch_word[BIT_IND]; // RULE21
      nxt_dec.mode_disp   = fetch_word[MD_HI:MD_LO]; // RULE21
      unique case (prim)
         OP_STACK: nxt_dec.group = GRP_STACK; // RULE2
         OP_SUB1: begin
            nxt_dec.group    = GRP_SUB1; // RULE2
            nxt_dec.indirect = fetch_word[BIT_X]; // RULE10
         end
         OP_SUB2, OP_SUB3: begin
            nxt_dec.group      = (prim == OP_SUB2) ? GRP_SUB2 : GRP_SUB3; // RULE2
            nxt_dec.mini_valid = (sub23 == SUB_MINI); // RULE4
            nxt_dec.mini_op    = (sub23 == SUB_MINI) ? fetch_word[MINI_HI:MINI_LO] : 4'h0; // RULE4 RULE19
         end
         default: begin
            if (prim == OP_STORE && fetch_word[LP_HI:LP_LO] == LOOP_MARK) begin
               nxt_dec.group      = GRP_LOOP; // RULE20
               nxt_dec.loop_minus = fetch_word[BIT_LP_SIGN]; // RULE20
               nxt_dec.loop_disp  = fetch_word[IMM_HI:IMM_LO]; // RULE20
            end else begin
               nxt_dec.group = GRP_MEM; // RULE21
            end
         end
      endcase
   end

   // latched word and decoded fields
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         word_ff      <= 16'h0000;
         dec_ff       <= '0; // RULE23
         dec_valid_ff <= 1'b0;
      end else begin
         dec_valid_ff <= accept; // RULE23
         if (accept) begin
            word_ff <= fetch_word;
            dec_ff  <= nxt_dec; // RULE23
         end
      end
   end

   // stack pair sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (accept && is_stack) begin
               nxt_state = ST_SLOT_A; // RULE6
            end
         end
         ST_SLOT_A: begin
            if (op_done) begin
               if (!right_valid_ff && lookahead_en) begin
                  nxt_state = ST_IDLE; // RULE8
               end else if (irq_pending) begin
                  nxt_state = ST_HELD; // RULE6
               end else begin
                  nxt_state = ST_SLOT_B; // RULE6
               end
            end
         end
         ST_SLOT_B: begin
            if (op_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_HELD: begin
            if (irq_resume) begin
               nxt_state = ST_SLOT_B; // RULE6
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != ST_IDLE);
      end
   end

   // slot issue towards the execution unit, one pulse per executed slot
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stack_op_ff    <= 6'h00;
         stack_issue_ff <= 1'b0;
         slot_b_ff      <= 1'b0;
      end else begin
         stack_issue_ff <= 1'b0;
         if (state_ff == ST_IDLE && nxt_state == ST_SLOT_A) begin
            stack_op_ff    <= fetch_word[SLOT_A_HI:SLOT_A_LO]; // RULE6
            stack_issue_ff <= 1'b1;
            slot_b_ff      <= 1'b0;
         end else if (nxt_state == ST_SLOT_B && state_ff != ST_SLOT_B) begin
            stack_op_ff    <= word_ff[SLOT_B_HI:SLOT_B_LO]; // RULE6
            stack_issue_ff <= 1'b1;
            slot_b_ff      <= 1'b1;
         end
      end
   end

   // interrupt acceptance between the two slots
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_take_ff <= 1'b0;
      end else begin
         irq_take_ff <= (state_ff == ST_SLOT_A) && (nxt_state == ST_HELD); // RULE6
      end
   end

   // right-slot flag survives the interrupt; resume from ST_HELD issues slot b without reading it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         right_valid_ff <= 1'b0;
      end else if (state_ff == ST_IDLE && nxt_state == ST_SLOT_A) begin
         right_valid_ff <= !b_is_nop; // RULE22
      end else if (nxt_state == ST_IDLE && state_ff != ST_IDLE) begin
         right_valid_ff <= 1'b0; // RULE22
      end
   end

   // each completed slot overwrites, so the last one executed is what stays
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ind_ff <= '0;
      end else if (op_done && (state_ff == ST_SLOT_A || state_ff == ST_SLOT_B)) begin
         ind_ff <= ind_in; // RULE7
      end
   end

   // register port: control write
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_ff <= {15'h0000, reg_wdata[CTRL_LOOKAHEAD]};
      end
   end

   // register port: read data valid the cycle after the strobe only
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:   rdata_ff <= ctrl_ff;
            REG_STATUS: rdata_ff <= {5'h00, ind_ff, busy_ff, irq_take_ff, state_ff, right_valid_ff};
            REG_WORD:   rdata_ff <= word_ff;
            default:    rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign reg_rdata        = rdata_ff;
   assign dec              = dec_ff;
   assign dec_valid        = dec_valid_ff;
   assign stack_op         = stack_op_ff;
   assign stack_issue      = stack_issue_ff;
   assign stack_slot_b     = slot_b_ff;
   assign irq_take         = irq_take_ff;
   assign indicators       = ind_ff;
   assign right_slot_valid = right_valid_ff;
   assign seq_busy         = busy_ff;

endmodule

//--- insn_decode_assertions.sv
// checker: port-level properties of the instruction format decoder
`timescale 1ns/100ps
module insn_decode_assertions
   import insn_decode_pkg::*;
(
   input wire logic                         ref_clk,
   input wire logic                         rstn,
   input wire logic [15:0]                  fetch_word,
   input wire logic                         fetch_load,
   input wire logic [15:0]                  index_reg,
   input wire logic                         op_done,
   input wire insn_decode_pkg::indicators_s ind_in,
   input wire logic                         irq_pending,
   input wire logic                         irq_resume,
   input wire logic [3:0]                   reg_addr,
   input wire logic [15:0]                  reg_wdata,
   input wire logic                         reg_wr,
   input wire insn_decode_pkg::decode_s     dec,
   input wire logic                         dec_valid,
   input wire logic [5:0]                   stack_op,
   input wire logic                         stack_issue,
   input wire logic                         stack_slot_b,
   input wire logic                         irq_take,
   input wire insn_decode_pkg::indicators_s indicators,
   input wire logic                         right_slot_valid,
   input wire logic                         seq_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic la_ff;
   // shadow of the lookahead enable, so a blank right slot is only expected to vanish when allowed
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         la_ff <= 1'b1;
      else if (reg_wr && reg_addr == REG_CTRL)
         la_ff <= reg_wdata[CTRL_LOOKAHEAD];
   end
   property p_accept; fetch_load && !seq_busy |=> dec_valid; endproperty
   a_accept: assert property (p_accept) else $error("accepted word gave no dec_valid");
   property p_primary; dec_valid |-> dec.primary == $past(fetch_word[15:12]); endproperty
   a_primary: assert property (p_primary) else $error("primary opcode wrong");
   property p_group;
      dec_valid |-> ((dec.group == GRP_STACK) == (dec.primary == OP_STACK)) && ((dec.group == GRP_SUB1)
         == (dec.primary == OP_SUB1)) && ((dec.group == GRP_SUB2) == (dec.primary == OP_SUB2));
   endproperty
   a_group: assert property (p_group) else $error("group class wrong");
   property p_subs;
      dec_valid |-> {dec.sub1_op, dec.sub_op} == $past({fetch_word[10:6], fetch_word[11:8]}) && dec.mini_op ==
         ($past(fetch_word[15:13] == 3'h1 && fetch_word[11:8] == 4'h0) ? $past(fetch_word[7:4]) : 4'h0);
   endproperty
   a_subs: assert property (p_subs) else $error("sub opcode fields wrong");
   property p_slots; dec_valid |-> {dec.slot_a, dec.slot_b} == $past(fetch_word[11:0]); endproperty
   a_slots: assert property (p_slots) else $error("stack slots wrong");
   property p_count;
      dec_valid |-> dec.count_eff == {10'h000, $past(fetch_word[5:0])} + ($past(fetch_word[11]) ? $past(index_reg) : 16'h0000);
   endproperty
   a_count: assert property (p_count) else $error("indexed count wrong");
   property p_first;
      dec_valid && dec.group == GRP_STACK |-> stack_issue && !stack_slot_b && stack_op == dec.slot_a;
   endproperty
   a_first: assert property (p_first) else $error("left slot not issued first");
   property p_rsv; dec_valid && dec.group == GRP_STACK |-> right_slot_valid == (dec.slot_b != NO_OPERATION); endproperty
   a_rsv: assert property (p_rsv) else $error("right slot flag wrong");
   property p_second; stack_issue && stack_slot_b |-> stack_op == dec.slot_b; endproperty
   a_second: assert property (p_second) else $error("right slot code wrong");
   property p_skip;
      seq_busy && op_done && !stack_slot_b && !irq_pending && la_ff && dec.slot_b == NO_OPERATION |=> !seq_busy && !stack_issue;
   endproperty
   a_skip: assert property (p_skip) else $error("blank right slot not skipped");
   property p_ind; seq_busy && op_done |=> indicators == $past(ind_in); endproperty
   a_ind: assert property (p_ind) else $error("indicators not from last slot");
   property p_irq;
      seq_busy && op_done && !stack_slot_b && irq_pending && right_slot_valid |=> irq_take ##1 (!stack_issue && seq_busy);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not taken between slots");
   property p_resume; seq_busy && !stack_slot_b && irq_resume |=> stack_issue && stack_slot_b; endproperty
   a_resume: assert property (p_resume) else $error("right slot not resumed");
   property p_end; seq_busy && stack_slot_b && op_done |=> !seq_busy && !right_slot_valid; endproperty
   a_end: assert property (p_end) else $error("pair did not end cleanly");
   c_pair: cover property (stack_issue && stack_slot_b);
   c_irq: cover property (irq_take);
   c_skip: cover property (seq_busy && op_done && !stack_slot_b && la_ff && dec.slot_b == NO_OPERATION);
endmodule

//--- exec_unit_model.sv
// execution-unit model: finishes each issued stack slot after a chosen latency
`timescale 1ns/100ps
module exec_unit_model
   import insn_decode_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   input  wire logic                   stack_issue,
   input  wire logic [5:0]             stack_op,
   input  wire logic [3:0]             latency,
   output logic                        op_done,
   output insn_decode_pkg::indicators_s ind_in
);
   logic       run_ff;
   logic [3:0] wait_ff;
   logic [5:0] op_ff;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         run_ff <= 1'b0;
         wait_ff <= 4'h0;
         op_ff <= 6'h00;
         op_done <= 1'b0;
         ind_in <= '0;
      end else if (stack_issue) begin
         run_ff <= 1'b1;
         wait_ff <= latency;
         op_ff <= stack_op;
         op_done <= 1'b0;
      end else if (run_ff && wait_ff == 4'h0) begin
         run_ff <= 1'b0;
         op_done <= 1'b1;
         ind_in <= indicators_s'(op_ff[3:0]);
      end else begin
         wait_ff <= wait_ff - 4'h1;
         op_done <= 1'b0;
         // indicators are only qualified by op_done, so scramble them otherwise
         ind_in <= indicators_s'(~ind_in);
      end
   end
endmodule

//--- tb_insn_decode.sv
// testbench: register port, field decode and stack-pair sequencing
`timescale 1ns/100ps
module tb_insn_decode;
   import insn_decode_pkg::*;
   logic        ref_clk;
   logic        rstn;
   logic [15:0] fetch_word;
   logic        fetch_load;
   logic [15:0] index_reg;
   logic        irq_pending;
   logic        irq_resume;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [3:0]  latency;
   logic [15:0] reg_rdata;
   decode_s     dec;
   logic        dec_valid;
   logic [5:0]  stack_op;
   logic        stack_issue;
   logic        stack_slot_b;
   logic        irq_take;
   logic        right_slot_valid;
   logic        seq_busy;
   logic        op_done;
   indicators_s ind_in;
   indicators_s indicators;
   int          bad_count;
   int          num_checks;
   int          p;
   logic [15:0] w;
   group_e      g;
   logic [5:0]  ops[$];
   insn_decode insn_decode_i (.*);
   exec_unit_model exec_unit_model_i (.*);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (stack_issue === 1'b1) ops.push_back(stack_op);
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata & m);
   endtask
   task automatic load(input logic [15:0] v);
      @(posedge ref_clk);
      fetch_word <= v;
      fetch_load <= 1'b1;
      @(posedge ref_clk);
      fetch_load <= 1'b0;
      #1;
      chk("dec_valid", 1, dec_valid);
      chk("primary", v[15:12], dec.primary);
   endtask
   // one stack word: lookahead, interrupt, latency, expected slot count
   task automatic pair(input logic [11:0] s, input logic la, input logic irq, input logic [3:0] lat, input int n);
      int i;
      logic [5:0] last;
      reg_write(REG_CTRL, {15'h0000, la});
      @(posedge ref_clk);
      latency <= lat;
      irq_pending <= irq;
      ops.delete();
      load({OP_STACK, s});
      chk("group", GRP_STACK, dec.group);
      chk("slots", s, {dec.slot_a, dec.slot_b});
      chk("rsv", s[5:0] != NO_OPERATION, right_slot_valid);
      if (irq) begin
         for (i = 0; i < 200 && irq_take !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
         end
         chk("irq_take", 1, irq_take);
         if (i == 200) stop_test();
         @(posedge ref_clk);
         irq_pending <= 1'b0;
         repeat (4) @(posedge ref_clk);
         #1;
         chk("held ops", 1, ops.size());
         reg_read(REG_STATUS, 16'h0041, 16'h0041);
         @(posedge ref_clk);
         irq_resume <= 1'b1;
         @(posedge ref_clk);
         irq_resume <= 1'b0;
      end else begin
         @(posedge ref_clk);
         fetch_word <= 16'h4321;
         fetch_load <= 1'b1;
         @(posedge ref_clk);
         fetch_load <= 1'b0;
         #1;
         chk("refused", {1'b0, OP_STACK}, {dec_valid, dec.primary});
      end
      for (i = 0; i < 200 && seq_busy !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 200) begin
         bad_count++;
         stop_test();
      end
      last = (n == 2) ? s[5:0] : s[11:6];
      chk("issued", n, ops.size());
      chk("slot a", s[11:6], ops[0]);
      if (n == 2) chk("slot b", s[5:0], ops[1]);
      chk("indicators", last[3:0], indicators);
   endtask
   initial begin
      #(40 * 60000);
      bad_count++;
      stop_test();
   end
   initial begin
      rstn = 1'b0;
      fetch_word = 16'h0000;
      fetch_load = 1'b0;
      index_reg = 16'h0000;
      irq_pending = 1'b0;
      irq_resume = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      latency = 4'h0;
      bad_count = 0;
      num_checks = 0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      chk("reset outs", 0, {dec, dec_valid, seq_busy, right_slot_valid, indicators});
      reg_read(REG_CTRL, 16'hffff, 16'h0001);
      reg_read(4'hf, 16'hffff, 16'h0000);
      reg_write(REG_CTRL, 16'hfffe);
      reg_read(REG_CTRL, 16'hffff, 16'h0000);
      index_reg <= 16'h0100;
      for (p = 1; p < 16; p++) begin
         w = {p[3:0], (p[0] ? 12'hca5 : 12'h35a)};
         load(w);
         g = p == 1 ? GRP_SUB1 : p == 2 ? GRP_SUB2 : p == 3 ? GRP_SUB3 : GRP_MEM;
         chk("group", g, dec.group);
         chk("subs", {w[10:6], w[11:8], (p inside {2, 3} && w[11:8] == 4'h0) ? w[7:4] : 4'h0},
             {dec.sub1_op, dec.sub_op, dec.mini_op});
         chk("branch", {w[11:10], w[5:0]}, {dec.index_bit, dec.indirect, dec.br_minus, dec.br_disp});
         chk("count", w[11] ? 16'h0100 + w[5:0] : {10'h000, w[5:0]}, dec.count_eff);
         chk("move", {w[7:4], w[1:0], w[0]}, {dec.move_op, dec.move_src_db, dec.move_sdec, dec.special_ext});
         chk("imm", {w[7:0], w[7:0]}, {dec.imm8, dec.field_start, dec.field_len});
         chk("regs", {w[6:0], w[3:0]}, {dec.reg_sel, dec.io_sdisp});
         chk("mem", {w[11] & w[10], w[9:0]}, {dec.post_index, dec.mode_disp});
      end
      load(16'h5f9a);
      chk("loop", {GRP_LOOP, 9'h19a}, {dec.group, dec.loop_minus, dec.loop_disp});
      load(16'h5a9a);
      chk("store", GRP_MEM, dec.group);
      pair(12'h56a, 1'b1, 1'b0, 4'h0, 2);
      pair(12'hfc0, 1'b1, 1'b0, 4'h2, 1);
      pair(12'h040, 1'b0, 1'b0, 4'h0, 2);
      pair(12'h1f8, 1'b1, 1'b1, 4'h5, 2);
      pair(12'h011, 1'b1, 1'b0, 4'h7, 2);
      stop_test();
   end
endmodule
bind insn_decode insn_decode_assertions insn_decode_assertions_i (.*);
